// ---- hw/pm_mode_pkg.sv ----
// constants for the program memory mode decoder
package pm_mode_pkg;

  localparam int          ADDR_W          = 21;
  localparam int          WORD_W          = 16;
  localparam int          REG_ADDR_W      = 4;
  localparam int          REG_DATA_W      = 8;

  // program memory mode field encodings
  localparam logic [1:0]  MODE_INTERNAL_ONLY = 2'h3;
  localparam logic [1:0]  MODE_EXTERNAL_ONLY = 2'h2;
  localparam logic [1:0]  MODE_BOOT_BLOCK    = 2'h1;
  localparam logic [1:0]  MODE_EXTENDED      = 2'h0;

  // address map limits
  localparam logic [20:0] BOOT_BLOCK_TOP  = 21'h0007ff;
  localparam logic [20:0] FLASH_TOP_48K   = 21'h00bfff;
  localparam logic [20:0] FLASH_TOP_64K   = 21'h00ffff;

  // vectors
  localparam logic [20:0] RESET_VECTOR    = 21'h000000;
  localparam logic [20:0] IRQ_HIGH_VECTOR = 21'h000008;
  localparam logic [20:0] IRQ_LOW_VECTOR  = 21'h000018;

  // access kinds on the program bus
  localparam logic [1:0]  KIND_FETCH      = 2'h0;
  localparam logic [1:0]  KIND_TABLE_RD   = 2'h1;
  localparam logic [1:0]  KIND_TABLE_WR   = 2'h2;

  // register offsets
  localparam logic [3:0]  REG_CONFIG_LOW  = 4'h0;
  localparam logic [3:0]  REG_MEM_CONTROL = 4'h1;
  localparam logic [3:0]  REG_STATUS      = 4'h2;

  // configuration byte layout and erased value
  localparam int          CFG_WAIT_EN_BIT = 7;
  localparam int          CFG_MODE_LSB    = 0;
  localparam logic [7:0]  CFG_IMPL_MASK   = 8'h83;
  localparam logic [7:0]  CFG_ERASED      = 8'h83;

  // memory control register layout
  localparam int          MEMCTL_WAIT_LSB = 4;
  localparam logic [7:0]  MEMCTL_MASK     = 8'h30;
  localparam logic [7:0]  MEMCTL_RESET    = 8'h00;

  localparam logic [1:0]  WAIT_NONE       = 2'h0;

endpackage : pm_mode_pkg

// ---- hw/pm_region_decode.sv ----
// address to memory region decode for one program memory mode
`timescale 1ns/10ps
module pm_region_decode (
  input  wire logic [1:0]  mode,
  input  wire logic        flash_64k,
  input  wire logic [20:0] addr,
  output logic             to_internal,
  output logic             to_external
);

  logic [20:0] flash_top;

  always_comb begin
    flash_top   = flash_64k ? pm_mode_pkg::FLASH_TOP_64K : pm_mode_pkg::FLASH_TOP_48K;
    to_internal = 1'b0;
    to_external = 1'b0;
    unique case (mode)
      pm_mode_pkg::MODE_EXTERNAL_ONLY: begin
        to_external = 1'b1;
      end
      pm_mode_pkg::MODE_BOOT_BLOCK: begin
        to_internal = (addr <= pm_mode_pkg::BOOT_BLOCK_TOP);
        to_external = (addr > pm_mode_pkg::BOOT_BLOCK_TOP);
      end
      pm_mode_pkg::MODE_INTERNAL_ONLY: begin
        to_internal = (addr <= flash_top);
      end
      pm_mode_pkg::MODE_EXTENDED: begin
        to_internal = (addr <= flash_top);
        to_external = (addr > flash_top);
      end
    endcase
  end

endmodule : pm_region_decode

// ---- hw/pm_vector_select.sv ----
// program counter load vector for reset and interrupt entry
`timescale 1ns/10ps
module pm_vector_select (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        irq_high,
  input  wire logic        irq_low,
  output logic             pc_load,
  output logic [20:0]      pc_vector
);

  logic        load_q;
  logic [20:0] vector_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      load_q   <= 1'b1;
      vector_q <= pm_mode_pkg::RESET_VECTOR;
    end else if (irq_high) begin
      load_q   <= 1'b1;
      vector_q <= pm_mode_pkg::IRQ_HIGH_VECTOR;
    end else if (irq_low) begin
      load_q   <= 1'b1;
      vector_q <= pm_mode_pkg::IRQ_LOW_VECTOR;
    end else begin
      load_q   <= 1'b0;
    end
  end

  assign pc_load   = load_q;
  assign pc_vector = vector_q;

endmodule : pm_vector_select

// ---- hw/program_memory_mode_decoder.sv ----
// program memory mode decoder: routes program bus accesses to flash or external memory
`timescale 1ns/10ps
module program_memory_mode_decoder #(
  parameter bit HAS_EXT_BUS = 1'b1,
  parameter bit FLASH_64K   = 1'b1
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // register port
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  // program bus from the core
  input  wire logic        PM_REQ,
  input  wire logic [1:0]  PM_KIND,
  input  wire logic [20:0] PM_ADDR,
  input  wire logic [15:0] PM_WDATA,
  output logic             PM_BUSY,
  output logic             PM_DONE,
  output logic      [15:0] PM_RDATA,
  // on-chip flash
  output logic             FLASH_REQ,
  output logic             FLASH_WR,
  output logic      [20:0] FLASH_ADDR,
  output logic      [15:0] FLASH_WDATA,
  input  wire logic [15:0] FLASH_RDATA,
  // external memory interface
  output logic             EXT_REQ,
  output logic      [1:0]  EXT_KIND,
  output logic      [20:0] EXT_ADDR,
  output logic      [15:0] EXT_WDATA,
  output logic      [1:0]  EXT_WAIT_STATES,
  input  wire logic        EXT_DONE,
  input  wire logic [15:0] EXT_RDATA,
  // vectors
  input  wire logic        IRQ_HIGH,
  input  wire logic        IRQ_LOW,
  output logic             PC_LOAD,
  output logic      [20:0] PC_VECTOR
);

  typedef enum logic [1:0] {ST_IDLE, ST_FLASH_ISSUE, ST_FLASH_DATA, ST_EXT} bus_state_t;

  bus_state_t  state_q;
  bus_state_t  state_d;

  logic [7:0]  config_q;
  logic [7:0]  memctl_q;
  logic [7:0]  reg_rdata_q;
  logic [1:0]  mode_eff;
  logic        internal_only;
  logic        to_internal;
  logic        to_external;
  logic        kind_ok;
  logic        accept;
  logic        pm_done_q;
  logic [15:0] pm_rdata_q;
  logic        flash_req_q;
  logic        flash_wr_q;
  logic [20:0] flash_addr_q;
  logic [15:0] flash_wdata_q;
  logic        ext_req_q;
  logic [1:0]  ext_kind_q;
  logic [20:0] ext_addr_q;
  logic [15:0] ext_wdata_q;
  logic [1:0]  wait_states_q;
  logic        is_write_q;
  logic [7:0]  memctl_vis;
  logic        start_int;
  logic        start_ext;

  function automatic logic [7:0] memctl_view(input logic [7:0] value, input logic int_only);
    memctl_view = int_only ? 8'h00 : (value & pm_mode_pkg::MEMCTL_MASK);
  endfunction : memctl_view

  // mode decode; program-space routing and the memory control register access both depend on it
  always_comb begin
    mode_eff = config_q[pm_mode_pkg::CFG_MODE_LSB +: 2];
    if (!HAS_EXT_BUS) begin
      mode_eff = pm_mode_pkg::MODE_INTERNAL_ONLY;
    end
  end

  assign internal_only = (mode_eff == pm_mode_pkg::MODE_INTERNAL_ONLY);

  // software view of the memory control register, gone in internal-only mode
  assign memctl_vis = memctl_view(memctl_q, internal_only);

  pm_region_decode u_decode (
    .mode        (mode_eff),
    .flash_64k   (FLASH_64K),
    .addr        (PM_ADDR),
    .to_internal (to_internal),
    .to_external (to_external)
  );

  pm_vector_select u_vectors (
    .clk       (CLK_SYS),
    .rst       (RST),
    .irq_high  (IRQ_HIGH),
    .irq_low   (IRQ_LOW),
    .pc_load   (PC_LOAD),
    .pc_vector (PC_VECTOR)
  );

  // fetch, table read and table write are allowed wherever the region is reachable; kind 3 is refused
  assign kind_ok = (PM_KIND == pm_mode_pkg::KIND_FETCH) ||
                   (PM_KIND == pm_mode_pkg::KIND_TABLE_RD) ||
                   (PM_KIND == pm_mode_pkg::KIND_TABLE_WR);
  assign accept  = PM_REQ && (state_q == ST_IDLE);

  // a request starts a flash or external cycle only when its region is reachable
  assign start_int = accept && kind_ok && to_internal;
  assign start_ext = accept && kind_ok && to_external;

  // configuration byte: unused bits forced low, erased value after reset
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      config_q <= pm_mode_pkg::CFG_ERASED;
    end else if (REG_WR && (REG_ADDR == pm_mode_pkg::REG_CONFIG_LOW)) begin
      config_q <= REG_WDATA & pm_mode_pkg::CFG_IMPL_MASK;
    end
  end

  // memory control register exists only outside internal-only mode
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      memctl_q <= pm_mode_pkg::MEMCTL_RESET;
    end else if (REG_WR && (REG_ADDR == pm_mode_pkg::REG_MEM_CONTROL) && !internal_only) begin
      memctl_q <= REG_WDATA & pm_mode_pkg::MEMCTL_MASK;
    end
  end

  // register read data valid only in the cycle after the read strobe
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      reg_rdata_q <= 8'h00;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        pm_mode_pkg::REG_CONFIG_LOW: begin
          reg_rdata_q <= config_q & pm_mode_pkg::CFG_IMPL_MASK;
        end
        pm_mode_pkg::REG_MEM_CONTROL: begin
          reg_rdata_q <= memctl_view(memctl_q, internal_only);
        end
        pm_mode_pkg::REG_STATUS: begin
          reg_rdata_q <= {2'h0, HAS_EXT_BUS, FLASH_64K, (state_q != ST_IDLE), 1'b0, mode_eff};
        end
        default: begin
          reg_rdata_q <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // wait count toward the external interface
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wait_states_q <= pm_mode_pkg::WAIT_NONE;
    end else if (config_q[pm_mode_pkg::CFG_WAIT_EN_BIT]) begin
      wait_states_q <= pm_mode_pkg::WAIT_NONE;
    end else begin
      wait_states_q <= memctl_vis[pm_mode_pkg::MEMCTL_WAIT_LSB +: 2];
    end
  end

  // program bus sequencer, independent of any data memory traffic
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start_int) begin
          state_d = ST_FLASH_ISSUE;
        end else if (start_ext) begin
          state_d = ST_EXT;
        end
      end
      ST_FLASH_ISSUE: begin
        state_d = ST_FLASH_DATA;
      end
      ST_FLASH_DATA: begin
        state_d = ST_IDLE;
      end
      ST_EXT: begin
        if (EXT_DONE) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // flash side: one-cycle request, data returns the cycle after
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      flash_req_q   <= 1'b0;
      flash_wr_q    <= 1'b0;
      flash_addr_q  <= 21'h000000;
      flash_wdata_q <= 16'h0000;
    end else if (start_int) begin
      flash_req_q   <= 1'b1;
      flash_wr_q    <= (PM_KIND == pm_mode_pkg::KIND_TABLE_WR);
      flash_addr_q  <= PM_ADDR;
      flash_wdata_q <= PM_WDATA;
    end else begin
      flash_req_q   <= 1'b0;
      flash_wr_q    <= 1'b0;
    end
  end

  // external side: request held until the interface reports done
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ext_req_q   <= 1'b0;
      ext_kind_q  <= pm_mode_pkg::KIND_FETCH;
      ext_addr_q  <= 21'h000000;
      ext_wdata_q <= 16'h0000;
    end else if (start_ext) begin
      ext_req_q   <= 1'b1;
      ext_kind_q  <= PM_KIND;
      ext_addr_q  <= PM_ADDR;
      ext_wdata_q <= PM_WDATA;
    end else if ((state_q == ST_EXT) && EXT_DONE) begin
      ext_req_q   <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      is_write_q <= 1'b0;
    end else if (accept) begin
      is_write_q <= (PM_KIND == pm_mode_pkg::KIND_TABLE_WR);
    end
  end

  // completion and read data back to the core
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pm_done_q  <= 1'b0;
      pm_rdata_q <= 16'h0000;
    end else if (accept && !(kind_ok && (to_internal || to_external))) begin
      pm_done_q  <= 1'b1;
      pm_rdata_q <= 16'h0000;
    end else if (state_q == ST_FLASH_DATA) begin
      pm_done_q  <= 1'b1;
      pm_rdata_q <= is_write_q ? 16'h0000 : FLASH_RDATA;
    end else if ((state_q == ST_EXT) && EXT_DONE) begin
      pm_done_q  <= 1'b1;
      pm_rdata_q <= is_write_q ? 16'h0000 : EXT_RDATA;
    end else begin
      pm_done_q  <= 1'b0;
    end
  end

  assign PM_BUSY         = (state_q != ST_IDLE);
  assign PM_DONE         = pm_done_q;
  assign PM_RDATA        = pm_rdata_q;
  assign REG_RDATA       = reg_rdata_q;
  assign FLASH_REQ       = flash_req_q;
  assign FLASH_WR        = flash_wr_q;
  assign FLASH_ADDR      = flash_addr_q;
  assign FLASH_WDATA     = flash_wdata_q;
  assign EXT_REQ         = ext_req_q;
  assign EXT_KIND        = ext_kind_q;
  assign EXT_ADDR        = ext_addr_q;
  assign EXT_WDATA       = ext_wdata_q;
  assign EXT_WAIT_STATES = wait_states_q;

endmodule : program_memory_mode_decoder

// ---- testbench/pm_mode_props.sv ----
// checker for the program memory mode decoder ports
`timescale 1ns/10ps
module pm_mode_props (
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic [3:0]  REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        PM_REQ,
  input wire logic [1:0]  PM_KIND,
  input wire logic [20:0] PM_ADDR,
  input wire logic        PM_BUSY,
  input wire logic        PM_DONE,
  input wire logic [15:0] PM_RDATA,
  input wire logic        FLASH_REQ,
  input wire logic        EXT_REQ,
  input wire logic [1:0]  EXT_KIND,
  input wire logic [20:0] EXT_ADDR,
  input wire logic [1:0]  EXT_WAIT_STATES,
  input wire logic        EXT_DONE,
  input wire logic        IRQ_HIGH,
  input wire logic        IRQ_LOW,
  input wire logic        PC_LOAD,
  input wire logic [20:0] PC_VECTOR
);
  logic [7:0] cfg_q;
  logic       take;
  // shadow of the configuration byte as written over the register port
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cfg_q <= pm_mode_pkg::CFG_ERASED;
    end else if (REG_WR && REG_ADDR == pm_mode_pkg::REG_CONFIG_LOW) begin
      cfg_q <= REG_WDATA & pm_mode_pkg::CFG_IMPL_MASK;
    end
  end
  assign take = PM_REQ && !PM_BUSY && PM_KIND != 2'h3;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  property p_irq_high; IRQ_HIGH |=> PC_LOAD && PC_VECTOR == 21'h000008; endproperty
  a_irq_high: assert property (p_irq_high) else $error("high vector wrong");
  property p_irq_low; IRQ_LOW && !IRQ_HIGH |=> PC_LOAD && PC_VECTOR == 21'h000018; endproperty
  a_irq_low: assert property (p_irq_low) else $error("low vector wrong");
  property p_ext_hold;
    EXT_REQ && !EXT_DONE |=> EXT_REQ && $stable(EXT_ADDR) && $stable(EXT_KIND);
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("external request moved");
  property p_ext_done; EXT_REQ && EXT_DONE |=> PM_DONE && !EXT_REQ; endproperty
  a_ext_done: assert property (p_ext_done) else $error("external answer late");
  property p_int_only; cfg_q[1:0] == 2'h3 |-> !EXT_REQ; endproperty
  a_int_only: assert property (p_int_only) else $error("external used internally");
  property p_ext_only; cfg_q[1:0] == 2'h2 |-> !FLASH_REQ; endproperty
  a_ext_only: assert property (p_ext_only) else $error("flash used externally");
  property p_no_wait; cfg_q[7] && $past(cfg_q[7]) |-> EXT_WAIT_STATES == 2'h0; endproperty
  a_no_wait: assert property (p_no_wait) else $error("waits while disabled");
  property p_flash_lat; FLASH_REQ |-> !PM_DONE ##2 PM_DONE; endproperty
  a_flash_lat: assert property (p_flash_lat) else $error("flash answer timing");
  property p_boot;
    take && cfg_q[1:0] == 2'h1 |=> ($past(PM_ADDR) <= 21'h0007ff) ? FLASH_REQ : EXT_REQ;
  endproperty
  a_boot: assert property (p_boot) else $error("boot split wrong");
  property p_zero;
    take && cfg_q[1:0] == 2'h3 && PM_ADDR > 21'h00ffff |=> PM_DONE && PM_RDATA == 16'h0000;
  endproperty
  a_zero: assert property (p_zero) else $error("empty space not zero");
  c_ext: cover property (EXT_REQ && EXT_DONE);
  c_flash: cover property (FLASH_REQ);
  c_busy_req: cover property (PM_REQ && PM_BUSY);
endmodule : pm_mode_props

// ---- testbench/ext_mem_model.sv ----
// external program memory answering requests after a short or long delay
`timescale 1ns/10ps
module ext_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ext_req,
  input  wire logic [20:0] ext_addr,
  input  wire logic        slow,
  output logic             ext_done,
  output logic      [15:0] ext_rdata
);
  logic [3:0] cnt_q;
  logic       fire;
  assign fire = ext_req && !ext_done && cnt_q == (slow ? 4'h5 : 4'h0);
  always_ff @(posedge clk) begin
    if (rst || !ext_req || ext_done) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    ext_done <= !rst && fire;
    // data only valid with the done pulse, otherwise a moving pattern
    ext_rdata <= fire ? ~ext_addr[15:0] : ext_rdata + 16'h1357;
  end
endmodule : ext_mem_model

// ---- testbench/testbench.sv ----
// self-checking bench for the program memory mode decoder
`timescale 1ns/10ps
module testbench;
  logic CLK_SYS, RST, REG_WR, REG_RD, PM_REQ, PM_BUSY, PM_DONE, FLASH_REQ, FLASH_WR;
  logic EXT_REQ, EXT_DONE, IRQ_HIGH, IRQ_LOW, PC_LOAD, slow;
  logic [3:0]  REG_ADDR;
  logic [7:0]  REG_WDATA, REG_RDATA;
  logic [1:0]  PM_KIND, EXT_KIND, EXT_WAIT_STATES, rg, ek;
  logic [20:0] PM_ADDR, FLASH_ADDR, EXT_ADDR, PC_VECTOR, ea;
  logic [15:0] PM_WDATA, PM_RDATA, FLASH_WDATA, FLASH_RDATA, EXT_WDATA, EXT_RDATA, d, ex;
  logic [16:0] wd;
  int bad_count, cmp_count;
  typedef struct packed {
    logic [1:0]  mode;
    logic [1:0]  kind;
    logic [20:0] addr;
    logic [1:0]  rg;
  } row_t;
  row_t rows [13] = '{
    '{2'h3, 2'h0, 21'h000000, 2'h1}, '{2'h3, 2'h1, 21'h00ffff, 2'h1},
    '{2'h3, 2'h0, 21'h010000, 2'h0}, '{2'h3, 2'h1, 21'h1fffff, 2'h0},
    '{2'h2, 2'h0, 21'h000000, 2'h2}, '{2'h2, 2'h1, 21'h00ffff, 2'h2},
    '{2'h2, 2'h2, 21'h000100, 2'h2}, '{2'h1, 2'h0, 21'h0007ff, 2'h1},
    '{2'h1, 2'h1, 21'h000800, 2'h2}, '{2'h0, 2'h2, 21'h00ffff, 2'h1},
    '{2'h0, 2'h0, 21'h010000, 2'h2}, '{2'h0, 2'h1, 21'h1fffff, 2'h2},
    '{2'h2, 2'h3, 21'h000100, 2'h0}};
  assign FLASH_RDATA = FLASH_ADDR[15:0] ^ 16'h5a5a;
  program_memory_mode_decoder dut_u (.CLK_SYS(CLK_SYS), .RST(RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .PM_REQ(PM_REQ), .PM_KIND(PM_KIND), .PM_ADDR(PM_ADDR), .PM_WDATA(PM_WDATA),
    .PM_BUSY(PM_BUSY), .PM_DONE(PM_DONE), .PM_RDATA(PM_RDATA), .FLASH_REQ(FLASH_REQ),
    .FLASH_WR(FLASH_WR), .FLASH_ADDR(FLASH_ADDR), .FLASH_WDATA(FLASH_WDATA),
    .FLASH_RDATA(FLASH_RDATA), .EXT_REQ(EXT_REQ), .EXT_KIND(EXT_KIND), .EXT_ADDR(EXT_ADDR),
    .EXT_WDATA(EXT_WDATA), .EXT_WAIT_STATES(EXT_WAIT_STATES), .EXT_DONE(EXT_DONE),
    .EXT_RDATA(EXT_RDATA), .IRQ_HIGH(IRQ_HIGH), .IRQ_LOW(IRQ_LOW), .PC_LOAD(PC_LOAD),
    .PC_VECTOR(PC_VECTOR));
  ext_mem_model mem_u (.clk(CLK_SYS), .rst(RST), .ext_req(EXT_REQ), .ext_addr(EXT_ADDR),
    .slow(slow), .ext_done(EXT_DONE), .ext_rdata(EXT_RDATA));
  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : cmp
  task automatic print_verdict;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge CLK_SYS);
    REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= v;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] e, input string m);
    @(posedge CLK_SYS);
    REG_RD <= 1'b1; REG_ADDR <= a;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    #1 cmp(REG_RDATA, e, m);
  endtask : reg_rd
  // one program access; hold keeps the request up while busy so it must be refused
  task automatic pm_access(input logic [1:0] k, input logic [20:0] a, input bit hold);
    bit dn;
    dn = 0; rg = 2'h0; wd = '0;
    @(posedge CLK_SYS);
    PM_REQ <= 1'b1; PM_KIND <= k; PM_ADDR <= a; PM_WDATA <= 16'hbeef;
    @(posedge CLK_SYS);
    PM_REQ <= hold;
    if (hold) PM_ADDR <= a ^ 21'h000001;
    for (int i = 0; i < 30 && !dn; i++) begin
      #1;
      if (FLASH_REQ === 1'b1) begin
        rg = 2'h1; wd = {FLASH_WR, FLASH_WDATA};
      end
      if (EXT_REQ === 1'b1) begin
        rg = 2'h2; ek = EXT_KIND; ea = EXT_ADDR; wd = {EXT_KIND == 2'h2, EXT_WDATA};
      end
      if (PM_DONE === 1'b1) dn = 1;
      else @(posedge CLK_SYS);
      if (i == 1 && !dn) PM_REQ <= 1'b0;
    end
    if (!dn) begin
      cmp(1'b0, 1'b1, "no done");
      print_verdict;
    end
    d = PM_RDATA;
  endtask : pm_access
  initial begin
    {RST, REG_WR, REG_RD, PM_REQ, IRQ_HIGH, IRQ_LOW, slow} = 7'h40;
    {REG_ADDR, REG_WDATA, PM_KIND, PM_ADDR, PM_WDATA} = '0;
    repeat (16) @(posedge CLK_SYS);
    RST <= 1'b0;
    reg_rd(4'h0, 8'h83, "config reset");
    reg_rd(4'h1, 8'h00, "memctl reset");
    reg_rd(4'hf, 8'h00, "unmapped read");
    reg_rd(4'h2, 8'h33, "status idle");
    reg_wr(4'h0, 8'hff);
    reg_rd(4'h0, 8'h83, "config unused bits");
    for (int r = 0; r < 13; r++) begin
      reg_wr(4'h0, {6'h20, rows[r].mode});
      pm_access(rows[r].kind, rows[r].addr, 1'b0);
      ex = rows[r].rg == 2'h1 ? rows[r].addr[15:0] ^ 16'h5a5a : ~rows[r].addr[15:0];
      if (rows[r].rg == 2'h0 || rows[r].kind == 2'h2) ex = 16'h0000;
      cmp(rg, rows[r].rg, "region");
      cmp(d, ex, "read data");
      if (rows[r].rg == 2'h2) cmp({ek, ea}, {rows[r].kind, rows[r].addr}, "ext req");
      if (rows[r].rg != 2'h0) cmp(wd[16], rows[r].kind == 2'h2, "write flag");
      if (rows[r].kind == 2'h2) cmp(wd[15:0], 16'hbeef, "write data");
    end
    reg_wr(4'h0, 8'h02);
    reg_wr(4'h1, 8'h3f);
    reg_rd(4'h1, 8'h30, "memctl write");
    @(posedge CLK_SYS);
    #1 cmp(EXT_WAIT_STATES, 2'h3, "wait count");
    slow <= 1'b1;
    pm_access(2'h0, 21'h012345, 1'b1);
    cmp(ea, 21'h012345, "busy request taken");
    repeat (4) begin
      @(posedge CLK_SYS);
      #1 cmp(EXT_REQ, 1'b0, "refused request ran");
    end
    reg_wr(4'h0, 8'h83);
    reg_wr(4'h1, 8'h10);
    reg_rd(4'h1, 8'h00, "memctl internal");
    #1 cmp(EXT_WAIT_STATES, 2'h0, "no waits");
    for (int i = 0; i < 2; i++) begin
      @(posedge CLK_SYS);
      {IRQ_HIGH, IRQ_LOW} <= i ? 2'h1 : 2'h2;
      @(posedge CLK_SYS);
      {IRQ_HIGH, IRQ_LOW} <= 2'h0;
      #1 cmp({PC_LOAD, PC_VECTOR}, {1'b1, i ? 21'h000018 : 21'h000008}, "vector");
    end
    // second reset in mid-run must restore the erased configuration
    reg_wr(4'h0, 8'h00);
    @(posedge CLK_SYS);
    RST <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    #1 cmp({PC_LOAD, PC_VECTOR}, {1'b1, 21'h000000}, "reset vector");
    @(posedge CLK_SYS);
    RST <= 1'b0;
    reg_rd(4'h0, 8'h83, "config after reset");
    #1 cmp(EXT_WAIT_STATES, 2'h0, "waits after reset");
    print_verdict;
  end
endmodule : testbench
bind program_memory_mode_decoder pm_mode_props props_u (.CLK_SYS(CLK_SYS), .RST(RST),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .PM_REQ(PM_REQ),
  .PM_KIND(PM_KIND), .PM_ADDR(PM_ADDR), .PM_BUSY(PM_BUSY), .PM_DONE(PM_DONE),
  .PM_RDATA(PM_RDATA), .FLASH_REQ(FLASH_REQ), .EXT_REQ(EXT_REQ), .EXT_KIND(EXT_KIND),
  .EXT_ADDR(EXT_ADDR), .EXT_WAIT_STATES(EXT_WAIT_STATES), .EXT_DONE(EXT_DONE),
  .IRQ_HIGH(IRQ_HIGH), .IRQ_LOW(IRQ_LOW), .PC_LOAD(PC_LOAD), .PC_VECTOR(PC_VECTOR));
